/* File: shared/rstc_pkg.sv */
// Package with register map, field positions, reset values and timing counts of the reset controller.
package rstc_pkg;

	// Register offsets on the plain register port (byte addresses).
	localparam logic [7:0] MODE_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CMD_OFS = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
	localparam logic [7:0] IRQ_EN_OFS = 8'h10;
	localparam logic [7:0] IRQ_CLR_OFS = 8'h14;

	// Mode register fields.
	localparam int URST_EN_BIT = 0;
	localparam int URST_IRQ_EN_BIT = 4;
	localparam int PIN_LEN_LSB = 8;
	localparam int PIN_LEN_W = 4;
	localparam logic [31:0] MODE_RST = 32'h0000_0001;

	// Status register fields.
	localparam int URST_FLAG_BIT = 0;
	localparam int EXT_LEVEL_BIT = 16;
	localparam int BUSY_BIT = 17;

	// Command register fields and key.
	localparam int PROC_RST_BIT = 0;
	localparam int PERIPH_RST_BIT = 2;
	localparam int PIN_RST_BIT = 3;
	localparam int CMD_KEY_LSB = 24;
	localparam logic [7:0] CMD_KEY = 8'hA5;

	// Interrupt event bits.
	localparam int IRQ_W = 2;
	localparam int EV_URST = 0;
	localparam int EV_SWRST = 1;

	// Oscillator startup wait, in slow clock cycles (slow clock enable ticks).
	localparam int STARTUP_SLOW_CYCLES = 64;
	// Slow clock rate and the reference rate; the divider makes one enable per slow cycle.
	localparam int REF_CLK_HZ = 125_000_000;
	localparam int SLOW_CLK_HZ = 32_768;
	localparam int SLOW_DIV = REF_CLK_HZ / SLOW_CLK_HZ;
	// Reset outputs stay asserted this many slow cycles after their cause.
	localparam int RST_HOLD_SLOW = 3;

	// Register port carrier.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Reset output carrier, all active low.
	typedef struct packed {
		logic proc_rst_n;
		logic periph_rst_n;
	} rst_out_t;

	typedef enum logic [1:0] {
		ST_STARTUP,
		ST_RUN,
		ST_RESET
	} rst_state_t;

endpackage : rstc_pkg

/* File: core/reset_controller_pin_manager.sv */
// Reset controller with startup counter, reset state manager and external reset pin manager.
// Contract
// - Startup, reset state and pin timing advance only on the slow clock enable; registers and interrupts run every reference cycle.
// - Processor reset output also resets the watchdog timer.
// - Peripheral reset output resets every embedded peripheral.
// - Resets assert on external pin events or software reset commands.
// - State manager requests pin assertion; pin manager then drives pin low.
// - Pin low assertion lasts a software programmed number of slow cycles; the pin manager drives it for the programmed length plus one.
// - Startup counter holds resets until oscillator startup time elapsed.
// - Pin sampled every slow cycle; low level reports a user reset.
// - User reset enable cleared means low pin triggers no reset.
// - Status bit shows current sampled pin level at any time.
// - User reset event flag sets as soon as pin assertion detected.
// - Event flag holds until status register read; the read clears it.
// - Interrupt enable set makes pin assertion raise interrupt instead of reset.
`timescale 1ns/1ps
module reset_controller_pin_manager
	import rstc_pkg::*;
#(
	parameter int SLOW_DIV_P = SLOW_DIV,
	parameter int STARTUP_P = STARTUP_SLOW_CYCLES
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire reg_req_t reg_req,
	output logic [31:0] rdata,
	input wire logic ext_reset_pin_in,
	output logic ext_reset_pin_out,
	output logic ext_reset_pin_oe,
	output rst_out_t rst_out,
	output logic wdt_rst_n,
	output logic irq
);

	logic [15:0] div_q;
	logic slow_en_q;
	logic [15:0] start_q;
	rst_state_t state_q;
	logic [2:0] hold_q;

	logic [1:0] sync_q;
	logic pin_prev_q;

	logic [31:0] reset_mode_reg_q;
	logic user_reset_event_flag_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [PIN_LEN_W:0] pin_cnt_q;

	logic pin_req;
	logic sw_req_q;
	logic sw_periph_q;
	logic sw_proc_q;
	logic periph_only_q;

	logic ext_reset_level;
	logic user_reset_enable;
	logic user_reset_irq_enable;
	logic pin_fall;
	logic user_rst;
	logic cmd_ok;
	logic status_rd;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] irq_stat_d;
	logic user_reset_event_flag_d;

	function automatic logic hit(input reg_req_t r, input logic [7:0] ofs, input logic wr);
		hit = (r.addr == ofs) && (wr ? r.wr : r.rd);
	endfunction : hit

	// Processor and watchdog share one decode so they can never drift apart.
	function automatic logic proc_asserted(input rst_state_t st, input logic periph_only);
		proc_asserted = st == ST_STARTUP || (st == ST_RESET && !periph_only);
	endfunction : proc_asserted

	assign ext_reset_level = sync_q[1];
	assign user_reset_enable = reset_mode_reg_q[URST_EN_BIT];
	assign user_reset_irq_enable = reset_mode_reg_q[URST_IRQ_EN_BIT];
	// A pin held low by this block is not taken as a user reset, else it would retrigger itself.
	always_comb begin
		pin_fall = 1'b0;
		user_rst = 1'b0;
		if (slow_en_q) begin
			pin_fall = pin_prev_q && !ext_reset_level;
			user_rst = !ext_reset_level && !ext_reset_pin_oe && user_reset_enable
				&& !user_reset_irq_enable;
		end
	end
	assign cmd_ok = hit(reg_req, CMD_OFS, 1'b1)
		&& reg_req.wdata[CMD_KEY_LSB +: 8] == CMD_KEY;
	assign status_rd = hit(reg_req, STATUS_OFS, 1'b0);
	assign ev[EV_URST] = pin_fall && user_reset_irq_enable;
	assign ev[EV_SWRST] = cmd_ok && (reg_req.wdata[PROC_RST_BIT] || reg_req.wdata[PERIPH_RST_BIT]);

	// Slow clock enable divider.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 16'h0000;
		end else if (div_q == 16'(SLOW_DIV_P - 1)) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// One enable pulse per slow cycle; every slow rate in the block keys off it.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			slow_en_q <= 1'b0;
		end else begin
			slow_en_q <= div_q == 16'(SLOW_DIV_P - 1);
		end
	end

	// Pin synchroniser; only the second stage is read.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sync_q <= 2'b11;
		end else begin
			sync_q <= {sync_q[0], ext_reset_pin_in};
		end
	end

	// Level at the previous slow cycle; reset high so no false edge follows reset.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_prev_q <= 1'b1;
		end else if (slow_en_q) begin
			pin_prev_q <= ext_reset_level;
		end
	end

	// Mode register.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reset_mode_reg_q <= MODE_RST;
		end else if (hit(reg_req, MODE_OFS, 1'b1)) begin
			reset_mode_reg_q <= reg_req.wdata;
		end
	end

	// Interrupt enable register.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_en_q <= '0;
		end else if (hit(reg_req, IRQ_EN_OFS, 1'b1)) begin
			irq_en_q <= reg_req.wdata[IRQ_W-1:0];
		end
	end

	// Event flag: the set wins over the clear by read, so no pin event is lost.
	always_comb begin
		user_reset_event_flag_d = user_reset_event_flag_q;
		if (status_rd) begin
			user_reset_event_flag_d = 1'b0;
		end
		if (pin_fall) begin
			user_reset_event_flag_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			user_reset_event_flag_q <= 1'b0;
		end else begin
			user_reset_event_flag_q <= user_reset_event_flag_d;
		end
	end

	// Sticky interrupt status with write-one-to-clear register; an event in the clear cycle stays.
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (hit(reg_req, IRQ_CLR_OFS, 1'b1)) begin
			irq_stat_d = irq_stat_q & ~reg_req.wdata[IRQ_W-1:0];
		end
		irq_stat_d = irq_stat_d | ev;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// Software commands are latched and taken on the next slow cycle.
	// A command that lands while a reset sequence runs is dropped at that slow cycle.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sw_req_q <= 1'b0;
		end else if (cmd_ok) begin
			sw_req_q <= reg_req.wdata[PIN_RST_BIT];
		end else if (slow_en_q) begin
			sw_req_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sw_proc_q <= 1'b0;
		end else if (cmd_ok) begin
			sw_proc_q <= reg_req.wdata[PROC_RST_BIT];
		end else if (slow_en_q) begin
			sw_proc_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sw_periph_q <= 1'b0;
		end else if (cmd_ok) begin
			sw_periph_q <= reg_req.wdata[PERIPH_RST_BIT];
		end else if (slow_en_q) begin
			sw_periph_q <= 1'b0;
		end
	end

	// Reset state manager with startup counter.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_STARTUP;
			start_q <= 16'h0000;
			hold_q <= 3'h0;
			periph_only_q <= 1'b0;
		end else if (slow_en_q) begin
			case (state_q)
				ST_STARTUP: begin
					if (start_q == 16'(STARTUP_P - 1)) begin
						state_q <= ST_RUN;
					end else begin
						start_q <= start_q + 16'h0001;
					end
				end
				ST_RUN: begin
					if (user_rst || sw_proc_q || sw_periph_q) begin
						state_q <= ST_RESET;
						hold_q <= 3'h0;
						periph_only_q <= sw_periph_q && !sw_proc_q && !user_rst;
					end
				end
				ST_RESET: begin
					if (hold_q == 3'(RST_HOLD_SLOW - 1)) begin
						state_q <= ST_RUN;
					end else begin
						hold_q <= hold_q + 3'h1;
					end
				end
				default: state_q <= ST_STARTUP;
			endcase
		end
	end

	// Reset outputs, registered.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_out <= '0;
		end else begin
			rst_out.proc_rst_n <= !proc_asserted(state_q, periph_only_q);
			rst_out.periph_rst_n <= state_q == ST_RUN;
		end
	end

	// Watchdog reset follows the processor reset exactly.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wdt_rst_n <= 1'b0;
		end else begin
			wdt_rst_n <= !proc_asserted(state_q, periph_only_q);
		end
	end

	// Pin assertion request: software pin reset, user reset or software processor reset; a peripheral-only reset does not drive the pin.
	always_comb begin
		pin_req = 1'b0;
		if (slow_en_q && state_q == ST_RUN) begin
			pin_req = sw_req_q || user_rst || sw_proc_q;
		end
	end

	// Pin drive value: low whenever the enable is up, high only inside reset.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext_reset_pin_out <= 1'b1;
		end else begin
			ext_reset_pin_out <= 1'b0;
		end
	end

	// Pin manager: drives low for the programmed length plus one slow cycle.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_cnt_q <= '0;
			ext_reset_pin_oe <= 1'b0;
		end else begin
			if (pin_req && !ext_reset_pin_oe) begin
				pin_cnt_q <= {1'b0, reset_mode_reg_q[PIN_LEN_LSB +: PIN_LEN_W]};
				ext_reset_pin_oe <= 1'b1;
			end else if (slow_en_q && ext_reset_pin_oe) begin
				if (pin_cnt_q == '0) begin
					ext_reset_pin_oe <= 1'b0;
				end else begin
					pin_cnt_q <= pin_cnt_q - 1'b1;
				end
			end
		end
	end

	// Read data, one cycle after the read strobe.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				MODE_OFS: begin
					rdata <= reset_mode_reg_q;
				end
				STATUS_OFS: begin
					rdata <= (32'(user_reset_event_flag_q) << URST_FLAG_BIT)
						| (32'(ext_reset_level) << EXT_LEVEL_BIT)
						| (32'(state_q != ST_RUN) << BUSY_BIT);
				end
				IRQ_STAT_OFS: begin
					rdata <= 32'(irq_stat_q);
				end
				IRQ_EN_OFS: begin
					rdata <= 32'(irq_en_q);
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

endmodule : reset_controller_pin_manager

/* File: verification/rstc_checks_assertions.sv */
// Port checker for the reset controller.
`timescale 1ns/1ps
module rstc_checks
	import rstc_pkg::*;
#(
	parameter int SLOW_DIV_P = 4,
	parameter int STARTUP_P = 4
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire reg_req_t reg_req,
	input wire logic [31:0] rdata,
	input wire logic ext_reset_pin_in,
	input wire logic ext_reset_pin_out,
	input wire logic ext_reset_pin_oe,
	input wire rst_out_t rst_out,
	input wire logic wdt_rst_n,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire logic cmd_wr = reg_req.wr && reg_req.addr == CMD_OFS && reg_req.wdata[31:24] == CMD_KEY;
	a_wdt_with_proc: assert property (wdt_rst_n == rst_out.proc_rst_n)
		else $error("watchdog reset differs from processor reset");
	a_pin_drive_low: assert property (ext_reset_pin_oe |-> !ext_reset_pin_out)
		else $error("pin driven but not low");
	a_pin_released: assert property ($rose(ext_reset_pin_oe) |-> ##[1:80] !ext_reset_pin_oe)
		else $error("pin drive not released");
	a_sw_proc_rst: assert property (cmd_wr && reg_req.wdata[PROC_RST_BIT] |-> ##[1:12] !rst_out.proc_rst_n)
		else $error("software processor reset missing");
	a_sw_periph_rst: assert property (cmd_wr && reg_req.wdata[PERIPH_RST_BIT]
		|-> ##[1:12] !rst_out.periph_rst_n)
		else $error("software peripheral reset missing");
	a_startup_hold: assert property ($rose(nrst) |-> !rst_out.proc_rst_n [*8])
		else $error("reset released before startup wait");
	a_irq_mask_off: assert property (reg_req.wr && reg_req.addr == IRQ_EN_OFS
		&& reg_req.wdata[IRQ_W-1:0] == 2'h0 |-> ##[2:3] !irq)
		else $error("interrupt stays up with all enables off");
	a_rdata_slot: assert property (!$past(reg_req.rd) |-> rdata == 32'h0)
		else $error("read data outside its slot");
endmodule : rstc_checks

/* File: verification/pin_partner.sv */
// Outside device sharing the reset pin, with the pin pull-up.
`timescale 1ns/1ps
module pin_partner (
	input wire logic pull_low,
	input wire logic drv_oe,
	input wire logic drv_out,
	output wire logic pin
);
	// Wired low: the pull-up wins only when every party lets go.
	assign pin = !(pull_low || (drv_oe && !drv_out));
endmodule : pin_partner

/* File: verification/reset_controller_pin_manager_test.sv */
// Self-checking bench for the reset controller.
`timescale 1ns/1ps
module reset_controller_pin_manager_test;
	import rstc_pkg::*;
	localparam int DIV = 4;
	localparam int SU = 4;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] exp;} row_t;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	reg_req_t req = '0;
	logic pull_low = 1'b0;
	logic [31:0] rdata, q;
	logic pin_oe, pin_out, irq, wdt_rst_n;
	wire logic pin;
	rst_out_t rst_out;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int lows, plows, oes, n;
	row_t rows[8] = '{
		'{1'b0, MODE_OFS, 32'h0, MODE_RST},
		'{1'b0, STATUS_OFS, 32'h0, 32'h0001_0000},
		'{1'b1, MODE_OFS, 32'h0000_0311, 32'h0},
		'{1'b0, MODE_OFS, 32'h0, 32'h0000_0311},
		'{1'b0, IRQ_EN_OFS, 32'h0, 32'h0},
		'{1'b1, IRQ_EN_OFS, 32'h0000_0003, 32'h0},
		'{1'b0, IRQ_EN_OFS, 32'h0, 32'h0000_0003},
		'{1'b0, 8'h20, 32'h0, 32'h0}};
	initial forever #4 ref_clk = ~ref_clk;
	reset_controller_pin_manager #(.SLOW_DIV_P(DIV), .STARTUP_P(SU)) uut (.ref_clk(ref_clk),
		.nrst(nrst), .reg_req(req), .rdata(rdata), .ext_reset_pin_in(pin), .irq(irq),
		.ext_reset_pin_out(pin_out), .ext_reset_pin_oe(pin_oe), .rst_out(rst_out),
		.wdt_rst_n(wdt_rst_n));
	pin_partner peer (.pull_low(pull_low), .drv_oe(pin_oe), .drv_out(pin_out), .pin(pin));
	always @(negedge ref_clk) begin
		lows += 32'(nrst && rst_out.proc_rst_n !== 1'b1);
		plows += 32'(nrst && rst_out.periph_rst_n !== 1'b1);
		oes += 32'(pin_oe !== 1'b0);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req <= '{a, d, w, !w};
		@(posedge ref_clk);
		req <= '0;
		@(negedge ref_clk);
		q = rdata;
	endtask : acc
	task automatic clr(input int c);
		repeat (c) @(posedge ref_clk);
		lows = 0;
		plows = 0;
		oes = 0;
	endtask : clr
	task automatic give_verdict;
		$display("compares=%0d errors=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : give_verdict
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		chk(32'({rst_out, pin_oe, irq}), 32'h0);
		nrst <= 1'b1;
		n = 0;
		while (rst_out.proc_rst_n !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(n >= DIV * SU && n < 200), 32'h1);
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk(q, rows[i].exp);
		end
		// Interrupt mode: the pin event must not assert the processor reset or drive the pin.
		clr(1);
		pull_low <= 1'b1;
		repeat (24) @(posedge ref_clk);
		acc(1'b0, STATUS_OFS, 32'h0);
		chk(q, 32'h0000_0001);
		chk(32'(irq), 32'h1);
		@(posedge ref_clk);
		pull_low <= 1'b0;
		repeat (24) @(posedge ref_clk);
		acc(1'b0, STATUS_OFS, 32'h0);
		chk(q, 32'h0001_0000);
		acc(1'b0, IRQ_STAT_OFS, 32'h0);
		chk(q, 32'h1);
		chk(32'(lows + oes), 32'h0);
		acc(1'b1, IRQ_CLR_OFS, 32'h3);
		acc(1'b0, IRQ_STAT_OFS, 32'h0);
		chk(q | 32'(irq), 32'h0);
		acc(1'b1, IRQ_EN_OFS, 32'h0);
		// Both enables off: only the event flag moves.
		acc(1'b1, MODE_OFS, 32'h0);
		clr(1);
		pull_low <= 1'b1;
		repeat (24) @(posedge ref_clk);
		pull_low <= 1'b0;
		repeat (24) @(posedge ref_clk);
		acc(1'b0, STATUS_OFS, 32'h0);
		chk(q, 32'h0001_0001);
		acc(1'b0, IRQ_STAT_OFS, 32'h0);
		chk(q + 32'(lows + oes), 32'h0);
		// Reset mode with a four slow cycle pin pulse.
		acc(1'b1, MODE_OFS, 32'h0000_0301);
		clr(1);
		pull_low <= 1'b1;
		// A short pull, gone before the own drive ends, so it cannot start a second reset.
		repeat (8) @(posedge ref_clk);
		pull_low <= 1'b0;
		repeat (120) @(posedge ref_clk);
		chk(32'(oes), 32'(4 * DIV));
		chk(32'(lows > 0 && plows > 0), 32'h1);
		acc(1'b0, STATUS_OFS, 32'h0);
		// Software resets; a write without the key must do nothing.
		clr(1);
		acc(1'b1, CMD_OFS, 32'h0000_0005);
		repeat (20) @(posedge ref_clk);
		chk(32'(lows + plows), 32'h0);
		clr(1);
		acc(1'b1, CMD_OFS, {CMD_KEY, 24'h4});
		repeat (20) @(posedge ref_clk);
		chk(32'(lows == 0 && plows > 0), 32'h1);
		clr(1);
		acc(1'b1, CMD_OFS, {CMD_KEY, 24'h1});
		repeat (20) @(posedge ref_clk);
		chk(32'(lows > 0), 32'h1);
		acc(1'b0, IRQ_STAT_OFS, 32'h0);
		chk(q, 32'h2);
		give_verdict();
	end
endmodule : reset_controller_pin_manager_test
bind reset_controller_pin_manager rstc_checks #(.SLOW_DIV_P(SLOW_DIV_P), .STARTUP_P(STARTUP_P))
	chk_i (.ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req), .rdata(rdata), .irq(irq),
	.ext_reset_pin_in(ext_reset_pin_in), .ext_reset_pin_out(ext_reset_pin_out),
	.ext_reset_pin_oe(ext_reset_pin_oe), .rst_out(rst_out), .wdt_rst_n(wdt_rst_n));
